// [rtl/boot_rom_strap_decoder.sv]
// Function
// [R1] 256K parts: strap out maps A,B low, flash high; strap in swaps.
// [R2] 512K parts: 512KB socket windows, low or high base by boot strap.
// [R3] 1M parts: 1MB socket windows fill one 2MB region, flash the other.
// [R4] 1M parts, flash disabled: sockets low always, flash never decoded.
// [R5] Boot strap picks whether flash or sockets sit at the low region.
// [R6] Eight readable jumpers form one register at a fixed address.
// [R7] Jumper bit reads zero when fitted and one when absent.
// [R8] Software keeps the boot-select jumper bit for map selection only.
// [R9] Clock strap picks slow peripheral clock or bus-rate clock.
// [R10] All peripheral ports share the one selected clock rate.
// [R11] Software sets the fast clock bit to match the clock strap.
// [R12] Auto mode: become system controller only in first slot.
// [R13] Controller strap: forced, automatic, or never controller.
// [R14] Indicator lights whenever acting as system controller.
// [R15] During peripheral DMA snoop drives low or enables per strap.
// [R16] Flash writes blocked unless the protect jumper is fitted.
// [R17] Strobe strap fitted drives strobe source, else line undriven.
// [R18] Map straps sampled after reset and held until next reset.
//
// The AXI4-Lite slave port was left to the implementer.
`default_nettype none
module boot_rom_strap_decoder #(
    parameter int unsigned SLOW_DIV = boot_strap_pkg::SLOW_PCLK_DIV
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    input  wire logic [31:0]                 s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [31:0]                 s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [31:0]                 s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [31:0]                      s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    input  wire boot_strap_pkg::lb_req_t     lb_req_i,
    input  wire logic                        dma_master_i,
    input  wire logic [7:0]                  jumper_pins_i,
    input  wire boot_strap_pkg::strap_pins_t strap_pins_i,
    output boot_strap_pkg::mem_sel_t         mem_sel_o,
    output logic                             pclk_fast_o,
    output logic                             pclk_en_o,
    output logic                             system_controller_indicator_o,
    output logic                             snoop_o,
    output logic                             snoop_oe_o,
    output logic                             strobe_o,
    output logic                             strobe_oe_o
);
    import boot_strap_pkg::*;

    typedef struct packed {
        logic [7:0]  jmp_s1;
        logic [7:0]  jmp_s2;
        strap_pins_t strap_s1;
        strap_pins_t strap_s2;
        logic [1:0]  cap_cnt;
        logic        cap_done;
        map_cfg_t    cfg;
        logic [7:0]  pclk_ctrl;
        logic [7:0]  strobe_div;
        logic [7:0]  pclk_cnt;
        logic        pclk_en;
        logic [7:0]  strobe_cnt;
        logic        strobe_lvl;
        mem_sel_t    sel;
        logic        sysctl;
        logic        snoop;
        logic        snoop_oe;
        logic        aw_got;
        logic [7:0]  aw_idx;
        logic        w_got;
        logic [7:0]  wdata;
        logic        wlane0;
        wr_state_t   wr_state;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

    localparam logic [7:0] SLOW_DIV_M1 = 8'(SLOW_DIV - 1);

    state_t s_q;
    state_t s_d;

    // Socket window size for a density
    function automatic logic [31:0] rom_size(input rom_density_t d);
        case (d)
            DENS_256K: rom_size = ROM_SIZE_256K;
            DENS_512K: rom_size = ROM_SIZE_512K;
            default:   rom_size = ROM_SIZE_1M;
        endcase
    endfunction : rom_size

    // Half-open window test
    function automatic logic in_win(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] size);
        in_win = (a >= base) && ((a - base) < size);
    endfunction : in_win

    // Register index from a byte address; upper bits alias
    function automatic logic [7:0] reg_idx(input logic [31:0] a);
        reg_idx = a[9:2];
    endfunction : reg_idx

    function automatic logic idx_mapped(input logic [7:0] i);
        idx_mapped = (i == IDX_STRAP_STATUS) || (i == IDX_STROBE_DIV) ||
                     (i == IDX_PCLK_CTRL) || (i == IDX_JUMPER_STATUS);
    endfunction : idx_mapped

    logic [31:0] rom_base;
    logic [31:0] flash_base;
    logic [31:0] rsz;
    logic        flash_on;
    logic        wr_fire;
    logic        rd_fire;
    logic [7:0]  ar_idx;
    logic [7:0]  strap_status;

    // Window bases follow the captured straps only
    always_comb begin
        rsz        = rom_size(s_q.cfg.density); // [R1] [R2] [R3]
        flash_on   = (s_q.cfg.density != DENS_1M_NOFLASH); // [R4]
        rom_base   = (s_q.cfg.boot_flash && flash_on) ?
                     BOOT_HIGH_BASE : BOOT_LOW_BASE; // [R5] [R4]
        flash_base = s_q.cfg.boot_flash ?
                     BOOT_LOW_BASE : BOOT_HIGH_BASE; // [R5]
    end

    // Handshakes
    assign s_axi_awready_o = !s_q.aw_got && (s_q.wr_state == WR_IDLE);
    assign s_axi_wready_o  = !s_q.w_got && (s_q.wr_state == WR_IDLE);
    assign s_axi_arready_o = !s_q.rvalid;
    assign wr_fire = s_q.aw_got && s_q.w_got && (s_q.wr_state == WR_IDLE);
    assign rd_fire = s_axi_arvalid_i && !s_q.rvalid;
    assign ar_idx  = reg_idx(s_axi_araddr_i);

    // Own status: captured map, controller role, clock strap agreement
    assign strap_status = {1'b0,
        s_q.pclk_ctrl[FAST_CLK_BIT] ^ s_q.strap_s2.fast_clk_strap,
        s_q.strap_s2.fast_clk_strap,
        s_q.sysctl,
        s_q.cfg.boot_flash,
        s_q.cap_done,
        s_q.cfg.density};

    always_comb begin
        s_d = s_q;

        // Two-stage synchronisers for every strap pin
        s_d.jmp_s1   = jumper_pins_i;
        s_d.jmp_s2   = s_q.jmp_s1;
        s_d.strap_s1 = strap_pins_i;
        s_d.strap_s2 = s_q.strap_s1;

        // Capture once synchronised values have settled
        if (!s_q.cap_done) begin
            if (s_q.cap_cnt == CAPTURE_DELAY) begin
                s_d.cap_done       = 1'b1; // [R18]
                s_d.cfg.density    =
                    rom_density_t'(s_q.strap_s2.density); // [R18]
                // Fitted jumper reads zero and selects flash boot
                s_d.cfg.boot_flash =
                    !s_q.jmp_s2[BOOT_SEL_JUMPER]; // [R18] [R5] [R8]
            end else begin
                s_d.cap_cnt = s_q.cap_cnt + 2'h1;
            end
        end

        // One enable for every peripheral port, fast or slow
        if (s_q.strap_s2.fast_clk_strap) begin
            s_d.pclk_en  = 1'b1; // [R9] [R10]
            s_d.pclk_cnt = 8'h00;
        end else if (s_q.pclk_cnt >= SLOW_DIV_M1) begin
            s_d.pclk_en  = 1'b1; // [R9] [R10]
            s_d.pclk_cnt = 8'h00;
        end else begin
            s_d.pclk_en  = 1'b0;
            s_d.pclk_cnt = s_q.pclk_cnt + 8'h01;
        end

        // Programmable strobe source, half period of divider plus one
        if (s_q.strobe_cnt >= s_q.strobe_div) begin
            s_d.strobe_cnt = 8'h00;
            s_d.strobe_lvl = !s_q.strobe_lvl;
        end else begin
            s_d.strobe_cnt = s_q.strobe_cnt + 8'h01;
        end

        // Controller role; no role at all when the strap is absent
        case (sysctl_mode_t'(s_q.strap_s2.sysctl_mode))
            SYSCTL_FORCED: s_d.sysctl = 1'b1; // [R13]
            SYSCTL_AUTO:   s_d.sysctl = s_q.strap_s2.first_slot; // [R12]
            default:       s_d.sysctl = 1'b0; // [R13]
        endcase

        // Snoop line only driven while a peripheral DMA owns the bus
        s_d.snoop_oe = dma_master_i; // [R15]
        s_d.snoop    = s_q.strap_s2.snoop_strap; // [R15]

        // Memory decode, registered; nothing until the map is captured
        s_d.sel = '0;
        if (lb_req_i.valid && s_q.cap_done) begin
            s_d.sel.rom_a = in_win(lb_req_i.addr, rom_base, rsz);
            s_d.sel.rom_b = in_win(lb_req_i.addr, rom_base + rsz, rsz);
            if (flash_on && in_win(lb_req_i.addr, flash_base,
                                   REGION_SIZE)) begin // [R4]
                // Blocked writes never select the part
                if (lb_req_i.write &&
                    !s_q.strap_s2.protect_fitted) begin
                    s_d.sel.flash_write_blocked = 1'b1; // [R16]
                end else begin
                    s_d.sel.flash = 1'b1; // [R16]
                end
            end
        end

        // Write channel: address and data in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_d.aw_got = 1'b1;
            s_d.aw_idx = reg_idx(s_axi_awaddr_i);
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_d.w_got  = 1'b1;
            s_d.wdata  = s_axi_wdata_i[7:0];
            s_d.wlane0 = s_axi_wstrb_i[0];
        end
        case (s_q.wr_state)
            WR_IDLE: begin
                if (wr_fire) begin
                    s_d.aw_got   = 1'b0;
                    s_d.w_got    = 1'b0;
                    s_d.wr_state = WR_RESP;
                    s_d.bresp    = idx_mapped(s_q.aw_idx) ?
                                   RESP_OKAY : RESP_SLVERR;
                    // Registers live in byte lane 0 only
                    if (s_q.wlane0) begin
                        if (s_q.aw_idx == IDX_PCLK_CTRL) begin
                            s_d.pclk_ctrl = s_q.wdata; // [R11]
                        end
                        if (s_q.aw_idx == IDX_STROBE_DIV) begin
                            s_d.strobe_div = s_q.wdata;
                        end
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    s_d.wr_state = WR_IDLE;
                end
            end
            default: s_d.wr_state = WR_IDLE;
        endcase

        // Read channel; unmapped reads return zero with an error
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
            case (ar_idx)
                IDX_STRAP_STATUS:  s_d.rdata = {24'h000000, strap_status};
                IDX_STROBE_DIV:    s_d.rdata = {24'h000000, s_q.strobe_div};
                IDX_PCLK_CTRL:     s_d.rdata = {24'h000000, s_q.pclk_ctrl};
                // Raw pin level: fitted jumper pulls low
                IDX_JUMPER_STATUS: s_d.rdata =
                    {24'h000000, s_q.jmp_s2}; // [R6] [R7]
                default:           s_d.rdata = 32'h00000000;
            endcase
        end else if (s_q.rvalid && s_axi_rready_i) begin
            s_d.rvalid = 1'b0;
        end
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q            <= '0;
            s_q.cfg        <= '{density: DENS_512K, boot_flash: 1'b0};
            s_q.pclk_ctrl  <= PCLK_CTRL_RESET;
            s_q.strobe_div <= STROBE_DIV_RESET;
            s_q.wr_state   <= WR_IDLE;
            s_q.jmp_s1     <= 8'hFF;
            s_q.jmp_s2     <= 8'hFF;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign mem_sel_o                     = s_q.sel;
    assign pclk_fast_o                   = s_q.strap_s2.fast_clk_strap;
    assign pclk_en_o                     = s_q.pclk_en;
    assign system_controller_indicator_o = s_q.sysctl; // [R14]
    assign snoop_o                       = s_q.snoop;
    assign snoop_oe_o                    = s_q.snoop_oe;
    assign strobe_o                      = s_q.strobe_lvl;
    assign strobe_oe_o                   = s_q.strap_s2.strobe_fitted; // [R17]
    assign s_axi_bvalid_o                = (s_q.wr_state == WR_RESP);
    assign s_axi_bresp_o                 = s_q.bresp;
    assign s_axi_rvalid_o                = s_q.rvalid;
    assign s_axi_rdata_o                 = s_q.rdata;
    assign s_axi_rresp_o                 = s_q.rresp;

endmodule : boot_rom_strap_decoder
`default_nettype wire

// [rtl/boot_strap_pkg.sv]
`default_nettype none
package boot_strap_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_STRAP_STATUS     = 8'h00;
    localparam logic [7:0]  IDX_STROBE_DIV       = 8'h01;
    localparam logic [7:0]  IDX_PCLK_CTRL        = 8'h1D;
    localparam logic [31:0] JUMPER_STATUS_OFFSET = 32'hFFF4202D;
    localparam logic [7:0]  IDX_JUMPER_STATUS    = JUMPER_STATUS_OFFSET[7:0];

    // Field positions and reset values
    localparam int unsigned FAST_CLK_BIT      = 0;
    localparam int unsigned BOOT_SEL_JUMPER   = 3;
    localparam logic [7:0]  PCLK_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  STROBE_DIV_RESET  = 8'h0F;

    // Boot memory map
    localparam logic [31:0] BOOT_LOW_BASE  = 32'hFF800000;
    localparam logic [31:0] BOOT_HIGH_BASE = 32'hFFA00000;
    localparam logic [31:0] REGION_SIZE    = 32'h00200000;
    localparam logic [31:0] ROM_SIZE_256K  = 32'h00040000;
    localparam logic [31:0] ROM_SIZE_512K  = 32'h00080000;
    localparam logic [31:0] ROM_SIZE_1M    = 32'h00100000;

    // Timing
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned SLOW_PCLK_HZ  = 8000000;
    localparam int unsigned SLOW_PCLK_DIV =
        (CLK_HZ + SLOW_PCLK_HZ - 1) / SLOW_PCLK_HZ;
    localparam logic [1:0]  CAPTURE_DELAY = 2'h2;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DENS_256K       = 2'h0,
        DENS_512K       = 2'h1,
        DENS_1M         = 2'h2,
        DENS_1M_NOFLASH = 2'h3
    } rom_density_t;

    typedef enum logic [1:0] {
        SYSCTL_NEVER  = 2'h0,
        SYSCTL_FORCED = 2'h1,
        SYSCTL_AUTO   = 2'h2
    } sysctl_mode_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef struct packed {
        logic [1:0] density;
        logic [1:0] sysctl_mode;
        logic       first_slot;
        logic       snoop_strap;
        logic       fast_clk_strap;
        logic       protect_fitted;
        logic       strobe_fitted;
    } strap_pins_t;

    typedef struct packed {
        rom_density_t density;
        logic         boot_flash;
    } map_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } lb_req_t;

    typedef struct packed {
        logic rom_a;
        logic rom_b;
        logic flash;
        logic flash_write_blocked;
    } mem_sel_t;

endpackage : boot_strap_pkg
`default_nettype wire

// [sim/boot_rom_strap_decoder_bench.sv]
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    errors++; $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); \
    end end
module boot_rom_strap_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import boot_strap_pkg::*;
    localparam int unsigned SLOW = 3;
    localparam logic [31:0] PTS [18] = '{32'hFF7FFFFF, 32'hFF800000,
        32'hFF83FFFF, 32'hFF840000, 32'hFF87FFFF, 32'hFF880000, 32'hFF8FFFFF,
        32'hFF900000, 32'hFF9FFFFF, 32'hFFA00000, 32'hFFA3FFFF, 32'hFFA40000,
        32'hFFA7FFFF, 32'hFFA80000, 32'hFFAFFFFF, 32'hFFB00000, 32'hFFBFFFFF,
        32'hFFC00000};
    logic        clock_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, flash_boot = 1'b0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_rready_i = 1'b0, dma_master_i = 1'b0, lb_seen = 1'b0;
    logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic [7:0]  user_fitted = '0, jumper_pins_i, cnt, tgl;
    lb_req_t     lb_req_i = '0;
    strap_pins_t straps = '0, strap_pins_i;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic        s_axi_arready_o, s_axi_rvalid_o, pclk_fast_o, pclk_en_o;
    logic        system_controller_indicator_o, snoop_o, snoop_oe_o;
    logic        strobe_o, strobe_oe_o, lvl;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    mem_sel_t    mem_sel_o;
    int          errors = 0, comparisons = 0;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    mem_sel_t    sq[$];

    boot_rom_strap_decoder #(.SLOW_DIV(SLOW)) u_dut (.clock_i, .rst_i,
        .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .lb_req_i, .dma_master_i,
        .jumper_pins_i, .strap_pins_i, .mem_sel_o, .pclk_fast_o, .pclk_en_o,
        .system_controller_indicator_o, .snoop_o, .snoop_oe_o, .strobe_o,
        .strobe_oe_o);
    strap_board_model u_board (.user_fitted_i(user_fitted),
        .flash_boot_i(flash_boot), .straps_i(straps),
        .jumper_pins_o(jumper_pins_i), .strap_pins_o(strap_pins_i));

    // Clock
    always #20 clock_i = ~clock_i;

    // Oldest note meets each answer as it appears
    always @(posedge clock_i) begin
        lb_seen <= lb_req_i.valid;
        // Peek then drop, so a mismatch print cannot pop twice
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            `CHK("write response", bq[0], s_axi_bresp_o)
            void'(bq.pop_front());
        end
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            `CHK("read response", rq[0][33:32], s_axi_rresp_o)
            if (rq[0][34])
                `CHK("read data", rq[0][31:0], s_axi_rdata_o)
            void'(rq.pop_front());
        end
        if (lb_seen) begin
            `CHK("memory select", sq[0], mem_sel_o)
            void'(sq.pop_front());
        end
    end

    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic timed_out;
        errors++;
        $display("CHECK FAILED handshake expected answer seen none");
        summarize();
    endtask : timed_out

    task automatic axi_write(input logic [31:0] a, d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge clock_i);
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_bready_i <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bready_i <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, input logic [34:0] e);
        rq.push_back(e);
        @(posedge clock_i);
        s_axi_arvalid_i <= 1'b1;
        s_axi_araddr_i <= a;
        s_axi_rready_i <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rready_i <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask : axi_read

    // Socket windows sit at the low base unless flash boots on a part with flash
    function automatic mem_sel_t map_exp(rom_density_t d, logic bf,
            logic prot, logic wr, logic [31:0] a);
        logic [31:0] sz, rb, fb;
        mem_sel_t    s;
        sz = d == DENS_256K ? ROM_SIZE_256K :
             d == DENS_512K ? ROM_SIZE_512K : ROM_SIZE_1M;
        rb = (bf && d != DENS_1M_NOFLASH) ? BOOT_HIGH_BASE : BOOT_LOW_BASE;
        fb = bf ? BOOT_LOW_BASE : BOOT_HIGH_BASE;
        s = '0;
        s.rom_a = a >= rb && a < rb + sz;
        s.rom_b = a >= rb + sz && a < rb + 2 * sz;
        s.flash = d != DENS_1M_NOFLASH && a >= fb && a < fb + REGION_SIZE;
        if (s.flash && wr && !prot) s = 4'b0001;
        return s;
    endfunction : map_exp

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clock_i);
    endtask : do_reset

    initial begin
        void'($urandom(95));
        // Registers: control reset value, RO jumpers, RW control, unmapped hole
        user_fitted <= 8'($urandom);
        flash_boot <= 1'b1;
        do_reset();
        axi_read(32'h74, {3'b100, 24'h0, PCLK_CTRL_RESET});
        axi_write(32'h74, 32'hA5, RESP_OKAY);
        axi_read(32'h74, {3'b100, 32'hA5});
        axi_write(32'hB4, 32'h0, RESP_OKAY);
        axi_read(32'hB4, {3'b100, 24'h0,
            ~{user_fitted[7:4], 1'b1, user_fitted[2:0]}});
        axi_write(32'h3FC, 32'h12, RESP_SLVERR);
        axi_read(32'h3FC, {1'b0, RESP_SLVERR, 32'h0});
        $display("test registers done");
        // Every density and boot choice; map must ignore later strap moves
        for (int i = 0; i < 8; i++) begin
            straps.density <= i[2:1];
            straps.protect_fitted <= i[1] ^ i[0];
            flash_boot <= i[0];
            do_reset();
            straps.density <= ~i[2:1];
            flash_boot <= ~i[0];
            for (int j = 0; j < 24; j++) begin
                lb_req_i.valid <= 1'b1;
                lb_req_i.write <= j[0];
                lb_req_i.addr <= j < 18 ? PTS[j] :
                    32'hFF7F0000 + $urandom % 32'h460000;
                @(posedge clock_i);
                sq.push_back(map_exp(rom_density_t'(i[2:1]), i[0],
                    i[1] ^ i[0], j[0], lb_req_i.addr));
            end
            lb_req_i.valid <= 1'b0;
            repeat (2) @(posedge clock_i);
        end
        $display("test memory map done");
        // Divider of two: strobe toggles every third cycle
        axi_write(32'h4, 32'h2, RESP_OKAY);
        // Live straps: controller, snoop, strobe and peripheral clock
        for (int m = 0; m < 8; m++) begin
            straps.sysctl_mode <= m[2:1];
            straps.first_slot <= m[0];
            straps.snoop_strap <= m[0];
            straps.strobe_fitted <= m[1];
            straps.fast_clk_strap <= m[2];
            dma_master_i <= m[1] ^ m[0];
            axi_write(32'h74, {31'h0, m[2]}, RESP_OKAY);
            repeat (6) @(posedge clock_i);
            `CHK("controller", m[2:1] == 1 || m == 5,
                system_controller_indicator_o)
            `CHK("snoop", {m[1] ^ m[0], m[0]}, {snoop_oe_o, snoop_o})
            `CHK("strobe drive", m[1], strobe_oe_o)
            `CHK("fast clock", m[2], pclk_fast_o)
            cnt = '0;
            tgl = '0;
            lvl = strobe_o;
            repeat (4 * SLOW) begin
                @(posedge clock_i);
                cnt += pclk_en_o;
                tgl += 8'(strobe_o ^ lvl);
                lvl = strobe_o;
            end
            `CHK("clock pulses", 8'(m[2] ? 4 * SLOW : 4), cnt)
            `CHK("strobe toggles", 8'h04, tgl)
        end
        $display("test live straps done");
        summarize();
    end
endmodule : boot_rom_strap_decoder_bench
`undef CHK
`default_nettype wire

// [sim/boot_rom_strap_decoder_checker.sv]
`default_nettype none
module boot_rom_strap_decoder_checker #(
    parameter int unsigned SLOW_DIV = 4
) (
    input wire logic                        clock_i,
    input wire logic                        rst_i,
    input wire logic                        ce_i,
    input wire boot_strap_pkg::lb_req_t     lb_req_i,
    input wire logic                        dma_master_i,
    input wire boot_strap_pkg::strap_pins_t strap_pins_i,
    input wire boot_strap_pkg::mem_sel_t    mem_sel_o,
    input wire logic                        pclk_fast_o,
    input wire logic                        pclk_en_o,
    input wire logic                        system_controller_indicator_o,
    input wire logic                        snoop_oe_o,
    input wire logic                        strobe_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import boot_strap_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);

    // Straps pass a two-stage synchroniser, so allow five stable cycles
    chk_snoop_oe_rise: assert property (dma_master_i |=> snoop_oe_o)
        else $error("snoop drive missing during dma");
    chk_snoop_oe_fall: assert property (!dma_master_i |=> !snoop_oe_o)
        else $error("snoop driven outside dma");
    chk_flash_block: assert property (mem_sel_o.flash_write_blocked
        |-> !mem_sel_o.flash && $past(lb_req_i.write))
        else $error("blocked flash write still selects flash");
    chk_sel_onehot: assert property (
        $onehot0({mem_sel_o.rom_a, mem_sel_o.rom_b, mem_sel_o.flash}))
        else $error("two boot devices selected");
    chk_sel_needs_req: assert property (!lb_req_i.valid
        |=> mem_sel_o == '0)
        else $error("device selected without request");
    chk_ctl_never: assert property ((strap_pins_i.sysctl_mode
        == SYSCTL_NEVER)[*5] |=> !system_controller_indicator_o)
        else $error("controller role taken with strap absent");
    chk_ctl_forced: assert property ((strap_pins_i.sysctl_mode
        == SYSCTL_FORCED)[*5] |=> system_controller_indicator_o)
        else $error("forced controller indicator dark");
    chk_ctl_auto_slot: assert property ((strap_pins_i.sysctl_mode
        == SYSCTL_AUTO && $stable(strap_pins_i.first_slot))[*5]
        |=> system_controller_indicator_o
            == $past(strap_pins_i.first_slot))
        else $error("auto controller does not follow slot");
    chk_fast_pclk: assert property (strap_pins_i.fast_clk_strap[*5]
        |=> pclk_fast_o && pclk_en_o)
        else $error("fast peripheral clock not selected");
    chk_strobe_oe: assert property ($stable(strap_pins_i.strobe_fitted)[*5]
        |=> strobe_oe_o == $past(strap_pins_i.strobe_fitted))
        else $error("strobe drive does not follow strap");
    // A divider of one would legally pulse every cycle
    if (SLOW_DIV > 1) begin : g_slow
        chk_slow_gap: assert property ((!pclk_fast_o)[*3] ##0 pclk_en_o
            |=> !pclk_en_o)
            else $error("slow peripheral enable pulses back to back");
    end
endmodule : boot_rom_strap_decoder_checker

bind boot_rom_strap_decoder boot_rom_strap_decoder_checker #(
    .SLOW_DIV(SLOW_DIV)
) u_chk (.clock_i, .rst_i, .ce_i, .lb_req_i, .dma_master_i, .strap_pins_i,
    .mem_sel_o, .pclk_fast_o, .pclk_en_o, .system_controller_indicator_o,
    .snoop_oe_o, .strobe_oe_o);
`default_nettype wire

// [sim/strap_board_model.sv]
`default_nettype none
module strap_board_model (
    input  wire logic [7:0]                  user_fitted_i,
    input  wire logic                        flash_boot_i,
    input  wire boot_strap_pkg::strap_pins_t straps_i,
    output logic [7:0]                       jumper_pins_o,
    output boot_strap_pkg::strap_pins_t      strap_pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import boot_strap_pkg::*;

    // Fitted jumper grounds its pin; boot jumper only carries the map choice
    always_comb begin
        jumper_pins_o = ~user_fitted_i;
        jumper_pins_o[BOOT_SEL_JUMPER] = ~flash_boot_i;
    end

    // Remaining straps are plain header levels
    assign strap_pins_o = straps_i;
endmodule : strap_board_model
`default_nettype wire
